/* hw/hdmap_pkg.sv */
// shared constants for the host memory port, device and host ends
package hdmap_pkg;
  // bus widths
  localparam int HDMAP_BUS_W = 16;
  localparam int HDMAP_ADDR_W = 14;
  localparam int HDMAP_PM_W = 24;
  // core-mapped register addresses in data space
  localparam logic [13:0] HDMAP_START_ADDR_OFS = 14'h3FE0;
  localparam logic [13:0] HDMAP_OVERLAY_OFS = 14'h3FE7;
  // first memory-mapped control register in data space
  localparam logic [13:0] HDMAP_CTRL_BASE = 14'h3FE0;
  // field positions in the latched address word
  localparam int HDMAP_LATCH_BIT = 15;
  localparam int HDMAP_SPACE_BIT = 14;
  // boot mode straps {c,b,a} selecting host boot
  localparam logic [2:0] HDMAP_BOOT_MODE = 3'h5;
  // reset values
  localparam logic [15:0] HDMAP_START_RST = 16'h0000;
  localparam logic [15:0] HDMAP_OVERLAY_RST = 16'h0000;
  // host command register offsets
  localparam logic [3:0] HDMAP_CMD_ADDR_OFS = 4'h0;
  localparam logic [3:0] HDMAP_CMD_WDATA_OFS = 4'h1;
  localparam logic [3:0] HDMAP_CMD_GO_OFS = 4'h2;
  localparam logic [3:0] HDMAP_CMD_STATUS_OFS = 4'h3;
  localparam logic [3:0] HDMAP_CMD_RDATA_OFS = 4'h4;
  // go register opcodes
  localparam logic [1:0] HDMAP_OP_LATCH = 2'h1;
  localparam logic [1:0] HDMAP_OP_WRITE = 2'h2;
  localparam logic [1:0] HDMAP_OP_READ = 2'h3;
  // core cycles the host counts down in its strobe state before it checks busy
  localparam int HDMAP_STROBE_CYC = 2;
endpackage

/* hw/hdmap_if.sv */
// link between the host and the device memory port
`timescale 1ns/100ps
interface hdmap_if;
  logic host_port_select_n;
  logic host_addr_latch_en;
  logic host_read_strobe_n;
  logic host_write_strobe_n;
  logic [15:0] host_bus_out;
  logic host_bus_oe;
  logic [15:0] dev_bus_out;
  logic dev_bus_oe;
  logic host_port_ack_n;
  logic [15:0] host_addr_data_bus;
  // resolved wire level
  assign host_addr_data_bus = host_bus_oe ? host_bus_out : (dev_bus_oe ? dev_bus_out : 16'hFFFF);
  modport dev (
    input host_port_select_n, host_addr_latch_en, host_read_strobe_n, host_write_strobe_n,
    input host_addr_data_bus,
    output dev_bus_out, dev_bus_oe, host_port_ack_n
  );
  modport host (
    output host_port_select_n, host_addr_latch_en, host_read_strobe_n, host_write_strobe_n,
    output host_bus_out, host_bus_oe,
    input host_addr_data_bus, host_port_ack_n
  );
endinterface

/* hw/hdmap_device.sv */
// device end: on-chip memories reached by the host port
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module hdmap_device
  import hdmap_pkg::*;
#(
  parameter int PM_DEPTH = 16384,
  parameter int DM_DEPTH = 16384
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // host link
  hdmap_if.dev link,
  // boot straps {c,b,a}
  input wire logic [2:0] boot_mode_i,
  // core register port
  input wire logic [13:0] core_addr_i,
  input wire logic [15:0] core_wdata_i,
  input wire logic core_wr_i,
  input wire logic core_rd_i,
  output logic [15:0] core_rdata_o,
  // core run state
  output logic core_run_o
);
  logic [23:0] pm_mem [PM_DEPTH];
  logic [15:0] dm_mem [DM_DEPTH];
  logic [15:0] start_addr_reg;
  logic [15:0] overlay_reg;
  logic half_reg;
  logic [15:0] pm_high_reg;
  logic ial_d_reg;
  logic rd_d_reg;
  logic wr_d_reg;
  logic req_wr_reg;
  logic [15:0] req_data_reg;
  logic boot_hold_reg;
  logic boot_seen_reg;
  logic [15:0] bus_out_reg;
  logic bus_oe_reg;
  logic ack_n_reg;
  logic [15:0] core_rdata_reg;
  typedef enum logic [1:0] {HDMAP_IDLE, HDMAP_SYNC, HDMAP_ACCESS, HDMAP_HOLD} hdmap_state_t;
  hdmap_state_t state_reg;
  logic [13:0] cur_addr;
  logic is_pm;
  logic sel;
  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic wr_start;
  logic latch_fall;
  logic last_half;

  // true when a data space address hits the control register block
  function automatic logic hdmap_is_ctrl(input logic [13:0] a);
    return a >= HDMAP_CTRL_BASE;
  endfunction

  assign cur_addr = start_addr_reg[HDMAP_ADDR_W-1:0];
  assign is_pm = start_addr_reg[HDMAP_SPACE_BIT];
  assign sel = !link.host_port_select_n;
  // strobe sampling whenever selected, whether or not the core runs
  assign rd_act = sel && !link.host_read_strobe_n;
  assign wr_act = sel && !link.host_write_strobe_n;
  assign rd_start = rd_act && !rd_d_reg;
  assign wr_start = wr_act && !wr_d_reg;
  assign latch_fall = ial_d_reg && !link.host_addr_latch_en && sel;
  // program words need a second half transfer
  assign last_half = !is_pm || half_reg;

  // strobe history for edge detection
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ial_d_reg <= 1'b0;
      rd_d_reg <= 1'b0;
      wr_d_reg <= 1'b0;
    end
    else
    begin
      ial_d_reg <= link.host_addr_latch_en;
      rd_d_reg <= rd_act;
      wr_d_reg <= wr_act;
    end
  end

  // access sequencer
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= HDMAP_IDLE;
      req_wr_reg <= 1'b0;
      req_data_reg <= 16'h0000;
      ack_n_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        HDMAP_IDLE:
        begin
          if (rd_start || wr_start)
          begin
            state_reg <= HDMAP_SYNC;
            req_wr_reg <= wr_start;
            req_data_reg <= link.host_addr_data_bus;
            ack_n_reg <= 1'b1;
          end
        end
        HDMAP_SYNC: state_reg <= HDMAP_ACCESS;
        HDMAP_ACCESS: state_reg <= HDMAP_HOLD;
        HDMAP_HOLD:
        begin
          if (!rd_act && !wr_act)
          begin
            state_reg <= HDMAP_IDLE;
            ack_n_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // start address, overlay and half tracking
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      start_addr_reg <= HDMAP_START_RST;
      overlay_reg <= HDMAP_OVERLAY_RST;
      half_reg <= 1'b0;
    end
    else if (latch_fall && !link.host_addr_data_bus[HDMAP_LATCH_BIT])
    begin
      start_addr_reg <= link.host_addr_data_bus;
      half_reg <= 1'b0;
    end
    else if (core_wr_i && core_addr_i == HDMAP_START_ADDR_OFS)
    begin
      start_addr_reg <= core_wdata_i;
      half_reg <= 1'b0;
    end
    else if (core_wr_i && core_addr_i == HDMAP_OVERLAY_OFS)
    begin
      overlay_reg <= core_wdata_i;
    end
    else if (state_reg == HDMAP_ACCESS)
    begin
      if (last_half)
      begin
        start_addr_reg[HDMAP_ADDR_W-1:0] <= cur_addr + 14'h0001;
      end
      half_reg <= is_pm && !half_reg;
    end
  end

  // memory writes from the host port and the core port
  always_ff @(posedge mclk_i)
  begin
    if (state_reg == HDMAP_ACCESS && req_wr_reg)
    begin
      if (is_pm && half_reg)
      begin
        pm_mem[cur_addr] <= {pm_high_reg, req_data_reg[7:0]};
      end
      else if (!is_pm && !hdmap_is_ctrl(cur_addr))
      begin
        dm_mem[cur_addr] <= req_data_reg;
      end
    end
    else if (core_wr_i && !hdmap_is_ctrl(core_addr_i))
    begin
      dm_mem[core_addr_i] <= core_wdata_i;
    end
  end

  // upper program bits 23:8 held between halves
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pm_high_reg <= 16'h0000;
    else if (state_reg == HDMAP_ACCESS && req_wr_reg && is_pm && !half_reg)
      pm_high_reg <= req_data_reg;
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      bus_out_reg <= 16'h0000;
      bus_oe_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == HDMAP_ACCESS && !req_wr_reg)
      begin
        // only memory data, never the address
        if (is_pm)
          bus_out_reg <= half_reg ? {8'h00, pm_mem[cur_addr][7:0]} : pm_mem[cur_addr][23:8];
        else
          bus_out_reg <= dm_mem[cur_addr];
      end
      bus_oe_reg <= rd_act && (state_reg == HDMAP_ACCESS || state_reg == HDMAP_HOLD);
    end
  end

  // boot hold and core register reads
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      boot_seen_reg <= 1'b0;
      boot_hold_reg <= 1'b0;
      core_rdata_reg <= 16'h0000;
    end
    else
    begin
      boot_seen_reg <= 1'b1;
      if (!boot_seen_reg)
        boot_hold_reg <= (boot_mode_i == HDMAP_BOOT_MODE);
      else if (state_reg == HDMAP_ACCESS && req_wr_reg && is_pm && half_reg && cur_addr == 14'h0000)
        boot_hold_reg <= 1'b0;
      if (core_rd_i)
      begin
        if (core_addr_i == HDMAP_START_ADDR_OFS)
          core_rdata_reg <= start_addr_reg;
        else if (core_addr_i == HDMAP_OVERLAY_OFS)
          core_rdata_reg <= overlay_reg;
        else
          core_rdata_reg <= dm_mem[core_addr_i];
      end
    end
  end

  assign link.dev_bus_out = bus_out_reg;
  assign link.dev_bus_oe = bus_oe_reg;
  assign link.host_port_ack_n = ack_n_reg;
  assign core_rdata_o = core_rdata_reg;
  assign core_run_o = boot_seen_reg && !boot_hold_reg;
endmodule // hdmap_device

/* hw/hdmap_host.sv */
// host end: drives the memory port from a small command register file
`timescale 1ns/100ps
module hdmap_host
  import hdmap_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // software port
  input wire logic [3:0] sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [15:0] sw_rdata_o,
  // device link
  hdmap_if.host link
);
  typedef enum logic [2:0] {HH_IDLE, HH_WAIT, HH_DRIVE, HH_STROBE, HH_DONE} hh_state_t;
  hh_state_t state_reg;
  logic [15:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [1:0] op_reg;
  logic [1:0] cnt_reg;
  logic sel_n_reg;
  logic ial_reg;
  logic rd_n_reg;
  logic wr_n_reg;
  logic [15:0] bus_reg;
  logic oe_reg;
  logic [15:0] sw_rdata_reg;
  logic busy;

  assign busy = state_reg != HH_IDLE;

  // command registers
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      addr_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
    end
    else if (sw_wr_i && sw_addr_i == HDMAP_CMD_ADDR_OFS)
      addr_reg <= sw_wdata_i & 16'h7FFF; // bit15 kept low
    else if (sw_wr_i && sw_addr_i == HDMAP_CMD_WDATA_OFS)
      wdata_reg <= sw_wdata_i;
  end

  // link sequencer
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= HH_IDLE;
      op_reg <= 2'h0;
      cnt_reg <= 2'h0;
      sel_n_reg <= 1'b1;
      ial_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      bus_reg <= 16'h0000;
      oe_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      unique case (state_reg)
        HH_IDLE:
          if (sw_wr_i && sw_addr_i == HDMAP_CMD_GO_OFS && sw_wdata_i[1:0] != 2'h0)
          begin
            op_reg <= sw_wdata_i[1:0];
            state_reg <= HH_WAIT;
          end
        HH_WAIT:
          if (!link.host_port_ack_n)
          begin
            state_reg <= HH_DRIVE;
            sel_n_reg <= 1'b0;
            ial_reg <= (op_reg == HDMAP_OP_LATCH);
            bus_reg <= (op_reg == HDMAP_OP_LATCH) ? addr_reg : wdata_reg;
            oe_reg <= (op_reg != HDMAP_OP_READ);
            cnt_reg <= 2'(HDMAP_STROBE_CYC);
          end
        HH_DRIVE:
        begin
          ial_reg <= 1'b0;
          rd_n_reg <= !(op_reg == HDMAP_OP_READ);
          wr_n_reg <= !(op_reg == HDMAP_OP_WRITE);
          state_reg <= (op_reg == HDMAP_OP_LATCH) ? HH_DONE : HH_STROBE;
        end
        HH_STROBE:
          // hold strobe until device has taken it
          // device drops busy only after strobe release, so leave once busy is seen
          if (cnt_reg != 2'h0)
            cnt_reg <= cnt_reg - 2'h1;
          else if (link.host_port_ack_n)
            state_reg <= HH_DONE;
        HH_DONE:
        begin
          if (!rd_n_reg)
            rdata_reg <= link.host_addr_data_bus;
          sel_n_reg <= 1'b1;
          rd_n_reg <= 1'b1;
          wr_n_reg <= 1'b1;
          oe_reg <= 1'b0;
          state_reg <= HH_IDLE;
        end
      endcase
    end
  end

  // software read data one cycle later
  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      sw_rdata_reg <= 16'h0000;
    else if (sw_rd_i)
      sw_rdata_reg <= (sw_addr_i == HDMAP_CMD_STATUS_OFS) ? {15'h0000, busy}
                    : (sw_addr_i == HDMAP_CMD_RDATA_OFS) ? rdata_reg
                    : (sw_addr_i == HDMAP_CMD_ADDR_OFS) ? addr_reg
                    : (sw_addr_i == HDMAP_CMD_WDATA_OFS) ? wdata_reg : 16'h0000;
  end

  assign sw_rdata_o = sw_rdata_reg;
  assign link.host_port_select_n = sel_n_reg;
  assign link.host_addr_latch_en = ial_reg;
  assign link.host_read_strobe_n = rd_n_reg;
  assign link.host_write_strobe_n = wr_n_reg;
  assign link.host_bus_out = bus_reg;
  assign link.host_bus_oe = oe_reg;
endmodule // hdmap_host

/* tb/hdmap_props.sv */
// link checks for the host memory port
`timescale 1ns/100ps
module hdmap_props (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // link
  input wire logic host_port_select_n,
  input wire logic host_addr_latch_en,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic host_bus_oe,
  input wire logic dev_bus_oe,
  input wire logic host_port_ack_n,
  input wire logic [15:0] host_addr_data_bus
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  // busy only after select with a strobe
  ack_cause_a: assert property (
    $rose(host_port_ack_n) |-> $past(!host_port_select_n && !(host_read_strobe_n && host_write_strobe_n)))
    else $error("ack raised without request");
  // sync plus access keeps busy two cycles
  ack_hold_a: assert property (
    $rose(host_port_ack_n) |=> host_port_ack_n)
    else $error("busy too short");
  // request answered promptly
  ack_soon_a: assert property (
    ($fell(host_write_strobe_n) || $fell(host_read_strobe_n)) && !host_port_select_n
    |-> ##[1:3] host_port_ack_n)
    else $error("request not taken");
  // ready again after release
  ack_free_a: assert property (
    $rose(host_write_strobe_n) || $rose(host_read_strobe_n) |-> ##[0:2] !host_port_ack_n)
    else $error("ack stuck busy");
  // host starts only when ready
  wait_ready_a: assert property (
    $fell(host_write_strobe_n) || $fell(host_read_strobe_n) |-> !$past(host_port_ack_n))
    else $error("strobe while busy");
  // device drives only during reads
  rd_drive_a: assert property (
    dev_bus_oe |-> $past(!host_read_strobe_n) && !host_bus_oe)
    else $error("device drives outside read");
  // read data appears in time
  read_data_a: assert property (
    $fell(host_read_strobe_n) && !host_port_select_n |-> ##[1:6] dev_bus_oe)
    else $error("read data late");
  // latch word has top bit low
  latch_bit_a: assert property (
    $fell(host_addr_latch_en) |-> $past(!host_addr_data_bus[15]))
    else $error("latch with top bit set");
  // never both strobes
  one_strobe_a: assert property (
    !(!host_read_strobe_n && !host_write_strobe_n))
    else $error("both strobes low");
endmodule // hdmap_props

/* tb/tb_hdmap.sv */
// bench joining host and device ends of the memory port
`timescale 1ns/100ps
module tb_hdmap;
  import hdmap_pkg::*;
  logic mclk_i;
  logic sys_rst_i;
  logic [2:0] boot_mode_i;
  logic [13:0] core_addr_i;
  logic [15:0] core_wdata_i;
  logic core_wr_i;
  logic core_rd_i;
  logic [15:0] core_rdata_o;
  logic core_run_o;
  logic [3:0] sw_addr_i;
  logic [15:0] sw_wdata_i;
  logic sw_wr_i;
  logic sw_rd_i;
  logic [15:0] sw_rdata_o;
  int miscompares;
  int checked;
  hdmap_if link_if ();
  hdmap_device u_hdmap_device (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link_if),
    .boot_mode_i(boot_mode_i), .core_addr_i(core_addr_i), .core_wdata_i(core_wdata_i),
    .core_wr_i(core_wr_i), .core_rd_i(core_rd_i), .core_rdata_o(core_rdata_o),
    .core_run_o(core_run_o));
  hdmap_host u_hdmap_host (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
    .link(link_if));
  hdmap_props u_hdmap_props (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .host_port_select_n(link_if.host_port_select_n),
    .host_addr_latch_en(link_if.host_addr_latch_en),
    .host_read_strobe_n(link_if.host_read_strobe_n),
    .host_write_strobe_n(link_if.host_write_strobe_n), .host_bus_oe(link_if.host_bus_oe),
    .dev_bus_oe(link_if.dev_bus_oe), .host_port_ack_n(link_if.host_port_ack_n),
    .host_addr_data_bus(link_if.host_addr_data_bus));
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic give_verdict;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // software and core port cycles, one idle edge after each
  task automatic sw_wr(input logic [3:0] a, input logic [15:0] d);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge mclk_i);
    sw_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic sw_rd(input logic [3:0] a, output logic [15:0] d);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge mclk_i);
    sw_rd_i <= 1'b0;
    #1;
    d = sw_rdata_o;
    @(posedge mclk_i);
  endtask
  task automatic core_wr(input logic [13:0] a, input logic [15:0] d);
    core_addr_i <= a;
    core_wdata_i <= d;
    core_wr_i <= 1'b1;
    @(posedge mclk_i);
    core_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic core_rd(input logic [13:0] a, output logic [15:0] d);
    core_addr_i <= a;
    core_rd_i <= 1'b1;
    @(posedge mclk_i);
    core_rd_i <= 1'b0;
    #1;
    d = core_rdata_o;
    @(posedge mclk_i);
  endtask
  // one host operation, waiting on busy with a bound
  task automatic go(input logic [1:0] op, input logic [15:0] d, output logic [15:0] r);
    logic [15:0] st;
    int n;
    sw_wr(HDMAP_CMD_WDATA_OFS, d);
    sw_wr(HDMAP_CMD_GO_OFS, {14'h0000, op});
    st = 16'h0001;
    n = 0;
    while (st[0] !== 1'b0 && n < 100)
    begin
      sw_rd(HDMAP_CMD_STATUS_OFS, st);
      n++;
    end
    if (n == 100)
      check(st, 16'h0000);
    sw_rd(HDMAP_CMD_RDATA_OFS, r);
  endtask
  task automatic latch(input logic [15:0] a);
    logic [15:0] r;
    sw_wr(HDMAP_CMD_ADDR_OFS, a);
    go(HDMAP_OP_LATCH, 16'h0000, r);
  endtask
  // reset values and unmapped software read
  task automatic reset_scn;
    logic [15:0] d;
    core_rd(HDMAP_START_ADDR_OFS, d);
    check(d, HDMAP_START_RST);
    core_rd(HDMAP_OVERLAY_OFS, d);
    check(d, HDMAP_OVERLAY_RST);
    sw_rd(4'hF, d);
    check(d, 16'h0000);
  endtask
  // host boot: core held until both halves of word 0 land
  task automatic boot_scn;
    logic [15:0] d;
    check({15'h0000, core_run_o}, 16'h0000);
    latch(16'h4000);
    go(HDMAP_OP_WRITE, 16'h1234, d);
    check({15'h0000, core_run_o}, 16'h0000);
    go(HDMAP_OP_WRITE, 16'h0056, d);
    check({15'h0000, core_run_o}, 16'h0001);
    latch(16'h4000);
    go(HDMAP_OP_READ, 16'h0000, d);
    check(d, 16'h1234);
    go(HDMAP_OP_READ, 16'h0000, d);
    check(d, 16'h0056);
  endtask
  // data block streamed from one start address
  task automatic stream_scn;
    logic [15:0] d;
    latch(16'h0010);
    for (int i = 0; i < 3; i++)
      go(HDMAP_OP_WRITE, 16'hA000 + 16'(i), d);
    latch(16'h0010);
    for (int i = 0; i < 3; i++)
    begin
      go(HDMAP_OP_READ, 16'h0000, d);
      check(d, 16'hA000 + 16'(i));
    end
    core_wr(HDMAP_START_ADDR_OFS, 16'h0011);
    go(HDMAP_OP_READ, 16'h0000, d);
    check(d, 16'hA001);
  endtask
  // control block shielded from host writes
  task automatic protect_scn;
    logic [15:0] d;
    latch({2'h0, HDMAP_OVERLAY_OFS});
    go(HDMAP_OP_WRITE, 16'h0003, d);
    core_rd(HDMAP_OVERLAY_OFS, d);
    check(d, HDMAP_OVERLAY_RST);
    core_wr(HDMAP_OVERLAY_OFS, 16'h0001);
    core_rd(HDMAP_OVERLAY_OFS, d);
    check(d, 16'h0001);
  endtask
  // clock
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    give_verdict;
  end
  // main sequence
  initial
  begin
    miscompares = 0;
    checked = 0;
    sys_rst_i = 1'b1;
    boot_mode_i = HDMAP_BOOT_MODE;
    core_addr_i = 14'h0000;
    core_wdata_i = 16'h0000;
    core_wr_i = 1'b0;
    core_rd_i = 1'b0;
    sw_addr_i = 4'h0;
    sw_wdata_i = 16'h0000;
    sw_wr_i = 1'b0;
    sw_rd_i = 1'b0;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    reset_scn;
    boot_scn;
    stream_scn;
    protect_scn;
    give_verdict;
  end
endmodule // tb_hdmap
